// ===== ddc_pkg.sv
// constants for the two-channel 8-bit converter control block
// assumes a 20 MHz peripheral clock and a 32-bit classic wishbone slave
package ddc_pkg;

  localparam int unsigned CLK_MHZ       = 20;
  localparam int unsigned CONV_TIME_NS  = 10000;
  // longest time: rounded down, never below one cycle
  localparam int unsigned CONV_CYC_RAW  = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONV_CYCLES   = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int unsigned CNT_W         = 8;

  localparam int unsigned ADR_W         = 8;
  localparam logic [7:0]  OFF_VALUE0    = 8'h00;
  localparam logic [7:0]  OFF_VALUE1    = 8'h04;
  localparam logic [7:0]  OFF_CONTROL   = 8'h08;
  localparam logic [7:0]  OFF_MSTOP     = 8'h0C;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;

  localparam int unsigned BIT_OE1       = 7;
  localparam int unsigned BIT_OE0       = 6;
  localparam int unsigned BIT_JOINT     = 5;
  localparam logic [4:0]  CTRL_RSVD     = 5'h1F;
  localparam logic [7:0]  VALUE_RST     = 8'h00;
  localparam logic        MSTOP_RST     = 1'b1;

  localparam int unsigned BIT_MSTOP     = 0;
  localparam int unsigned BIT_DONE0     = 0;
  localparam int unsigned BIT_DONE1     = 1;
  localparam int unsigned BIT_BUSY0     = 2;
  localparam int unsigned BIT_BUSY1     = 3;
  localparam int unsigned BIT_STANDBY   = 4;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_CONV = 2'b01,
    CH_HOLD = 2'b10
  } ddc_ch_state_t;

endpackage : ddc_pkg

// ===== ddc_dual_dac_control.sv
// digital control of a two-channel 8-bit converter, wishbone register slave
// assumes bus, standby request and clock enable all come from the ref_clk domain
//
// What this block does
// - all three enables clear: nothing converts or drives
// - joint off: each channel follows own enable
// - joint on: both convert, outputs follow enables
// - enable rise starts conversion, output after time
// - output holds until rewrite or enable cleared
// - value write restarts conversion, new output later
// - requested level is value over 256 times reference
// - clearing output enable stops driving two clock edges after the write
// - block starts halted in module-stop state
// - register accesses other than module stop ignored while module stopped
// - standby keeps analog outputs at present values
// - per-channel 8-bit readable writable value register
module ddc_dual_dac_control (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        softStandby,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [7:0]  analog_out_0,
  output logic      [7:0]  analog_out_1,
  output logic             analogOutEn0,
  output logic             analogOutEn1,
  output logic      [1:0]  convDone,
  output logic      [1:0]  convBusy
);

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0]  chValue [2];
  logic        joint_convert_enable;
  logic        ch0_output_enable;
  logic        ch1_output_enable;
  logic        moduleStop;
  logic [1:0]  outEnable;
  logic [1:0]  convRun;
  logic [1:0]  valueWr;
  logic        busReq;
  logic        busWrite;
  logic        busRead;
  logic        regOpen;
  logic        frozen;
  logic [31:0] next_rdData;

  // standby freezes conversion progress but the outputs stay driven
  assign frozen  = softStandby;
  assign busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign regOpen = ~moduleStop | (wb_adr_i == ddc_pkg::OFF_MSTOP);
  assign busWrite = busReq & wb_we_i & wb_sel_i[0] & regOpen;
  assign busRead  = busReq & ~wb_we_i;

  assign outEnable = {ch1_output_enable, ch0_output_enable};

  //////////////////////////////////////////////////////////////////////////////
  // wishbone handshake: one wait state, ack for one cycle

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (clkEn) begin
      wb_ack_o <= busReq;
    end
  end

  always_comb begin
    next_rdData = 32'h0000_0000;
    case (wb_adr_i)
      ddc_pkg::OFF_VALUE0: begin
        next_rdData[7:0] = chValue[0];
      end
      ddc_pkg::OFF_VALUE1: begin
        next_rdData[7:0] = chValue[1];
      end
      ddc_pkg::OFF_CONTROL: begin
        next_rdData[ddc_pkg::BIT_OE1]   = ch1_output_enable;
        next_rdData[ddc_pkg::BIT_OE0]   = ch0_output_enable;
        next_rdData[ddc_pkg::BIT_JOINT] = joint_convert_enable;
        next_rdData[4:0]                = ddc_pkg::CTRL_RSVD;
      end
      ddc_pkg::OFF_MSTOP: begin
        next_rdData[ddc_pkg::BIT_MSTOP] = moduleStop;
      end
      ddc_pkg::OFF_STATUS: begin
        next_rdData[ddc_pkg::BIT_DONE0]   = convDone[0];
        next_rdData[ddc_pkg::BIT_DONE1]   = convDone[1];
        next_rdData[ddc_pkg::BIT_BUSY0]   = convBusy[0];
        next_rdData[ddc_pkg::BIT_BUSY1]   = convBusy[1];
        next_rdData[ddc_pkg::BIT_STANDBY] = softStandby;
      end
      default: begin
        next_rdData = 32'h0000_0000;
      end
    endcase
  end

  // a stopped block answers reads other than module stop with zero so the bus never hangs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      if (busRead && regOpen) begin
        wb_dat_o <= next_rdData;
      end else if (busRead) begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // module stop: halted from reset until software clears it

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      moduleStop <= ddc_pkg::MSTOP_RST;
    end else if (clkEn) begin
      if (busWrite && wb_adr_i == ddc_pkg::OFF_MSTOP) begin
        moduleStop <= wb_dat_i[ddc_pkg::BIT_MSTOP];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      joint_convert_enable <= 1'b0;
      ch0_output_enable    <= 1'b0;
      ch1_output_enable    <= 1'b0;
    end else if (clkEn) begin
      if (busWrite && wb_adr_i == ddc_pkg::OFF_CONTROL) begin
        joint_convert_enable <= wb_dat_i[ddc_pkg::BIT_JOINT];
        ch0_output_enable    <= wb_dat_i[ddc_pkg::BIT_OE0];
        ch1_output_enable    <= wb_dat_i[ddc_pkg::BIT_OE1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel value register, sequencer and output

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      localparam logic [7:0] VAL_OFF = (ch == 0) ? ddc_pkg::OFF_VALUE0
                                                 : ddc_pkg::OFF_VALUE1;
      ddc_pkg::ddc_ch_state_t       state;
      ddc_pkg::ddc_ch_state_t       next_state;
      logic [ddc_pkg::CNT_W-1:0]    count;
      logic                         runPrev;
      logic                         oePrev;
      logic                         pend;
      logic                         start;
      logic [7:0]                   outCode;
      logic                         drive;

      assign valueWr[ch] = busWrite && (wb_adr_i == VAL_OFF);

      // joint enable forces conversion, output still follows the own enable
      assign convRun[ch] = ~moduleStop
                         & (joint_convert_enable | outEnable[ch]);

      // a rising run, a rising own enable or a value write restarts the count;
      // the own enable matters when joint mode already keeps the channel running
      assign start = convRun[ch]
                   & (~runPrev | (outEnable[ch] & ~oePrev) | valueWr[ch] | pend);

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          chValue[ch] <= ddc_pkg::VALUE_RST;
        end else if (clkEn && valueWr[ch]) begin
          chValue[ch] <= wb_dat_i[7:0];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          runPrev <= 1'b0;
          oePrev  <= 1'b0;
        end else if (clkEn && !frozen) begin
          runPrev <= convRun[ch];
          oePrev  <= outEnable[ch];
        end
      end

      // a value written in standby stays pending, so it still converts after
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pend <= 1'b0;
        end else if (clkEn) begin
          if (frozen && valueWr[ch]) begin
            pend <= 1'b1;
          end else if (!frozen) begin
            pend <= 1'b0;
          end
        end
      end

      always_comb begin
        next_state = state;
        case (state)
          ddc_pkg::CH_IDLE: begin
            if (start) begin
              next_state = ddc_pkg::CH_CONV;
            end
          end
          ddc_pkg::CH_CONV: begin
            if (!convRun[ch]) begin
              next_state = ddc_pkg::CH_IDLE;
            end else if (!start && count == 1) begin
              next_state = ddc_pkg::CH_HOLD;
            end
          end
          ddc_pkg::CH_HOLD: begin
            if (!convRun[ch]) begin
              next_state = ddc_pkg::CH_IDLE;
            end else if (start) begin
              next_state = ddc_pkg::CH_CONV;
            end
          end
          default: begin
            next_state = ddc_pkg::CH_IDLE;
          end
        endcase
      end

      // standby: the sequence is frozen, so whatever is driven stays put
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          state <= ddc_pkg::CH_IDLE;
        end else if (clkEn && !frozen) begin
          state <= next_state;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          count <= '0;
        end else if (clkEn && !frozen) begin
          if (start) begin
            count <= ddc_pkg::CNT_W'(ddc_pkg::CONV_CYCLES);
          end else if (state == ddc_pkg::CH_CONV && count != 0) begin
            count <= count - 1'b1;
          end
        end
      end

      // the code is value/256 of the reference: the 8-bit value passes as is
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          outCode <= 8'h00;
        end else if (clkEn && !frozen) begin
          if (state == ddc_pkg::CH_CONV && next_state == ddc_pkg::CH_HOLD) begin
            outCode <= chValue[ch];
          end
        end
      end

      // the old result keeps driving during a restart; the pin is first driven
      // once a conversion has finished, and dropped two clock edges after the
      // enable clears, even in standby
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          drive <= 1'b0;
        end else if (clkEn) begin
          if (!outEnable[ch] || moduleStop) begin
            drive <= 1'b0;
          end else if (!frozen && state == ddc_pkg::CH_CONV
                       && next_state == ddc_pkg::CH_HOLD) begin
            drive <= 1'b1;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          convDone[ch] <= 1'b0;
          convBusy[ch] <= 1'b0;
        end else if (clkEn && !frozen) begin
          convDone[ch] <= (next_state == ddc_pkg::CH_HOLD);
          convBusy[ch] <= (next_state == ddc_pkg::CH_CONV);
        end
      end

      if (ch == 0) begin : g_out0
        always_ff @(posedge ref_clk) begin
          if (rst) begin
            analog_out_0 <= 8'h00;
            analogOutEn0 <= 1'b0;
          end else if (clkEn) begin
            analog_out_0 <= outCode;
            analogOutEn0 <= drive;
          end
        end
      end else begin : g_out1
        always_ff @(posedge ref_clk) begin
          if (rst) begin
            analog_out_1 <= 8'h00;
            analogOutEn1 <= 1'b0;
          end else if (clkEn) begin
            analog_out_1 <= outCode;
            analogOutEn1 <= drive;
          end
        end
      end
    end
  endgenerate

endmodule : ddc_dual_dac_control

// ===== ddc_dac_monitor.sv
// checker for the converter control block, watching its ports only
// assumes clkEn stays high while a bus cycle or a conversion runs
////////////////////////////////////////////////////////////////////
module ddc_dac_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        softStandby,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  analog_out_0,
  input wire logic        analogOutEn0,
  input wire logic [1:0]  convDone,
  input wire logic [1:0]  convBusy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  ack_follows_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // reset itself is watched, so the default disable is switched off here
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !analogOutEn0 && !convBusy[0])
    else $error("outputs active after reset");
  // one cycle of slack beyond the two-edge drop
  oe_clear_a: assert property (wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0]
    && wb_adr_i == ddc_pkg::OFF_CONTROL && !wb_dat_i[ddc_pkg::BIT_OE0]
    |-> ##[1:3] !analogOutEn0)
    else $error("output enable not dropped");
  done0_cause_a: assert property ($rose(convDone[0]) |-> $past(convBusy[0]))
    else $error("done0 without conversion");
  done1_cause_a: assert property ($rose(convDone[1]) |-> $past(convBusy[1]))
    else $error("done1 without conversion");
  en_cause_a: assert property ($rose(analogOutEn0) |-> $past(convDone[0]))
    else $error("output enabled before result");
  code_cause_a: assert property ($changed(analog_out_0) |-> $past(convDone[0]))
    else $error("code changed without result");
  standby_hold_a: assert property (softStandby [*3] |=> $stable(analog_out_0))
    else $error("output moved in standby");
endmodule : ddc_dac_monitor

bind ddc_dual_dac_control ddc_dac_monitor u_ddc_dac_monitor (.ref_clk, .rst, .softStandby,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .analog_out_0,
  .analogOutEn0, .convDone, .convBusy);

// ===== test_dual_dac_control.sv
// self-checking bench for the two-channel converter control block
// assumes one-cycle bus answers and the package conversion count
module test_dual_dac_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        softStandby = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o, rdat;
  logic        wb_ack_o, analogOutEn0, analogOutEn1;
  logic [7:0]  analog_out_0, analog_out_1, v0, v1;
  logic [1:0]  convDone, convBusy, mask;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n;
  always #25 ref_clk = ~ref_clk;
  ddc_dual_dac_control u_ddc_dual_dac_control (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .clkEn        (clkEn),
    .softStandby  (softStandby),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_dat_i     (wb_dat_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .analog_out_0 (analog_out_0),
    .analog_out_1 (analog_out_1),
    .analogOutEn0 (analogOutEn0),
    .analogOutEn1 (analogOutEn1),
    .convDone     (convDone),
    .convBusy     (convBusy)
  );
  ////////////////////////////////////////////////////////////////////
  // enables follow the output bits only; joint mode converts both
  function automatic logic [1:0] expEn(logic [7:0] ctl);
    return ctl[7:6];
  endfunction : expEn
  function automatic logic [1:0] expDone(logic [7:0] ctl);
    return ctl[5] ? 2'b11 : ctl[7:6];
  endfunction : expDone
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // read data taken only at the ack edge, then one idle cycle
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  task automatic waitOut0(logic [7:0] val);
    n = 0;
    while (analog_out_0 !== val && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : waitOut0
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      $display("MISMATCH run length expected end seen hang");
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h8F4F96F6));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b1, ddc_pkg::OFF_VALUE0, 32'hA5);
    wb(1'b0, ddc_pkg::OFF_MSTOP, 32'h0);
    chk("mstop", 32'h1, rdat);
    wb(1'b0, ddc_pkg::OFF_CONTROL, 32'h0);
    chk("ctl stopped", 32'h0, rdat);
    wb(1'b1, ddc_pkg::OFF_MSTOP, 32'h0);
    wb(1'b0, ddc_pkg::OFF_VALUE0, 32'h0);
    chk("value0 dropped", 32'h0, rdat);
    wb(1'b0, ddc_pkg::OFF_CONTROL, 32'h0);
    chk("ctl reset", 32'h1F, rdat);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rdat);
    $display("reset test done");
    v0 = 8'($urandom()) | 8'h80;
    wb(1'b1, ddc_pkg::OFF_VALUE0, 32'(v0));
    wb(1'b0, ddc_pkg::OFF_VALUE0, 32'h0);
    chk("value0", 32'(v0), rdat);
    wb(1'b1, ddc_pkg::OFF_CONTROL, 32'h40);
    chk("busy", 32'h1, 32'(convBusy));
    waitOut0(v0);
    chk("conv cycles", ddc_pkg::CONV_CYCLES + 1, n);
    chk("en0", 32'h1, 32'(analogOutEn0));
    chk("en1 off", 32'h0, 32'(analogOutEn1));
    $display("single channel test done");
    v1 = 8'($urandom()) | 8'h01;
    wb(1'b1, ddc_pkg::OFF_VALUE1, 32'(v1));
    wb(1'b0, ddc_pkg::OFF_VALUE1, 32'h0);
    chk("value1", 32'(v1), rdat);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, ddc_pkg::OFF_CONTROL, 32'(i) << 5);
      repeat (ddc_pkg::CONV_CYCLES + 10) @(posedge ref_clk);
      mask = expDone(8'(i) << 5);
      chk("enables", 32'(expEn(8'(i) << 5)), 32'({analogOutEn1, analogOutEn0}));
      chk("done", 32'(mask), 32'(convDone));
    end
    chk("code1", 32'(v1), 32'(analog_out_1));
    wb(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'h3, rdat);
    $display("control table test done");
    v1 = v0 ^ (8'($urandom()) | 8'h01);
    wb(1'b1, ddc_pkg::OFF_VALUE0, 32'(~v0));
    repeat (50) @(posedge ref_clk);
    chk("held", 32'(v0), 32'(analog_out_0));
    wb(1'b1, ddc_pkg::OFF_VALUE0, 32'(v1));
    waitOut0(v1);
    chk("restart cycles", ddc_pkg::CONV_CYCLES, n);
    $display("rewrite test done");
    softStandby <= 1'b1;
    wb(1'b1, ddc_pkg::OFF_VALUE0, 32'(v0));
    clkEn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    clkEn <= 1'b1;
    repeat (250) @(posedge ref_clk);
    chk("standby out", 32'(v1), 32'(analog_out_0));
    chk("standby en", 32'h1, 32'(analogOutEn0));
    wb(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk("standby status", 32'h13, rdat);
    softStandby <= 1'b0;
    waitOut0(v0);
    chk("after standby", 32'(v0), 32'(analog_out_0));
    $display("standby test done");
    wb(1'b1, ddc_pkg::OFF_MSTOP, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk("stop en", 32'h0, 32'({analogOutEn1, analogOutEn0}));
    wb(1'b0, ddc_pkg::OFF_VALUE0, 32'h0);
    chk("stopped read", 32'h0, rdat);
    $display("module stop test done");
    finish_test();
  end
endmodule : test_dual_dac_control
